// ===== hdl/lfd_ctrl.sv
// Display controller end: writes data, sends mode commands, runs detection.
`timescale 1ns/1ps
module lfd_ctrl
    import lfd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    lfd_link_if.ctl link,
    input wire logic i_op_valid,
    input wire lfd_op_t i_op,
    input wire logic [WORD_W-1:0] i_wdata,
    output logic o_op_ready,
    output logic o_done,
    output logic [WORD_W-1:0] o_status
);

////////////////////////////////////////////////////////////////////////////////
// Shift-clock divider and serial_out synchroniser.

    logic [3:0] div_ff;
    logic tick;
    logic [1:0] serial_out_sync_ff;

    assign tick = div_ff == SCK_HALF_CYC - 4'h1;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || tick)
        begin
            div_ff <= 4'h0;
        end
        else
        begin
            div_ff <= div_ff + 4'h1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            serial_out_sync_ff <= 2'h0;
        end
        else
        begin
            serial_out_sync_ff <= {serial_out_sync_ff[0], link.serial_out};
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Sequencer.

    lfd_cstate_t state_ff;
    logic sck_ff;
    logic sin_ff;
    logic lat_n_ff;
    logic oe_n_ff;
    logic done_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [9:0] wait_ff;
    logic [2:0] code_ff;
    logic [WORD_W-1:0] data_ff;
    logic [WORD_W-1:0] rx_ff;
    logic rise_ok;
    logic [2:0] code_sel;

    // Each code bit after the first is set a half period ahead of its rise, the first 1 to 4 cycles: the device synchronises
    // the two pins apart, so oe_n must never move at a shift-clock rise.
    assign code_sel = i_op == OP_MODE_OPEN ? CODE_OPEN :
        i_op == OP_MODE_SHORT ? CODE_SHORT : CODE_NORMAL;

    // Third rise waits for the settle time
    assign rise_ok = state_ff != C_DET || cnt_ff != LAST_DET || wait_ff >= SETTLE_CYC;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || oe_n_ff)
        begin
            wait_ff <= 10'h0;
        end
        else if (wait_ff != SETTLE_CYC)
        begin
            wait_ff <= wait_ff + 10'h1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_ff <= C_IDLE;
            sck_ff <= 1'b0;
            sin_ff <= 1'b0;
            lat_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            done_ff <= 1'b0;
            cnt_ff <= 5'h0;
            code_ff <= 3'h0;
            data_ff <= {WORD_W{1'b0}};
            rx_ff <= {WORD_W{1'b0}};
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                C_IDLE:
                begin
                    cnt_ff <= 5'h0;
                    if (i_op_valid)
                    begin
                        case (i_op)
                            OP_WRITE:
                            begin
                                data_ff <= {i_wdata[WORD_W-2:0], 1'b0};
                                sin_ff <= i_wdata[WORD_W-1];
                                state_ff <= C_SHIFT;
                            end
                            OP_DETECT:
                            begin
                                oe_n_ff <= 1'b0;
                                sin_ff <= 1'b0;
                                state_ff <= C_DET;
                            end
                            default:
                            begin
                                // Strobe low, first code bit on oe_n
                                oe_n_ff <= code_sel[2];
                                code_ff <= {code_sel[1:0], 1'b0};
                                lat_n_ff <= 1'b0;
                                state_ff <= C_CMD;
                            end
                        endcase
                    end
                end
                C_SHIFT:
                begin
                    if (tick)
                    begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff)
                        begin
                            cnt_ff <= cnt_ff + 5'h1;
                            sin_ff <= data_ff[WORD_W-1];
                            data_ff <= {data_ff[WORD_W-2:0], 1'b0};
                            if (cnt_ff == LAST_BIT)
                            begin
                                lat_n_ff <= 1'b0;
                                state_ff <= C_LATCH;
                            end
                        end
                    end
                end
                C_LATCH:
                begin
                    if (tick)
                    begin
                        lat_n_ff <= 1'b1;
                        done_ff <= 1'b1;
                        state_ff <= C_IDLE;
                    end
                end
                C_CMD:
                begin
                    if (tick)
                    begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff)
                        begin
                            oe_n_ff <= code_ff[2];
                            code_ff <= {code_ff[1:0], 1'b0};
                            cnt_ff <= cnt_ff + 5'h1;
                            if (cnt_ff == LAST_CODE)
                            begin
                                lat_n_ff <= 1'b1;
                                oe_n_ff <= 1'b1;
                                done_ff <= 1'b1;
                                state_ff <= C_IDLE;
                            end
                        end
                    end
                end
                C_DET:
                begin
                    if (tick && (sck_ff || rise_ok))
                    begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff)
                        begin
                            cnt_ff <= cnt_ff + 5'h1;
                            if (cnt_ff == LAST_DET)
                            begin
                                oe_n_ff <= 1'b1;
                                cnt_ff <= 5'h0;
                                state_ff <= C_READ;
                            end
                        end
                    end
                end
                C_READ:
                begin
                    if (tick)
                    begin
                        sck_ff <= ~sck_ff;
                        if (!sck_ff)
                        begin
                            rx_ff <= {rx_ff[WORD_W-2:0], serial_out_sync_ff[1]};
                        end
                        else
                        begin
                            cnt_ff <= cnt_ff + 5'h1;
                            if (cnt_ff == LAST_BIT)
                            begin
                                done_ff <= 1'b1;
                                state_ff <= C_IDLE;
                            end
                        end
                    end
                end
                default:
                begin
                    state_ff <= C_IDLE;
                end
            endcase
        end
    end

    assign o_op_ready = state_ff == C_IDLE;
    assign o_done = done_ff;
    assign o_status = rx_ff;
    assign link.sck = sck_ff;
    assign link.serial_in = sin_ff;
    assign link.latch_strobe_n = lat_n_ff;
    assign link.oe_n = oe_n_ff;
endmodule

// ===== hdl/lfd_pkg.sv
// Shared constants and types for the LED fault-detect link.
package lfd_pkg;
    // Width of the shift register, one bit per output.
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    // Mode command: oe_n levels sampled at shift-clock rises under the strobe.
    localparam int CODE_LEN = 3;
    localparam logic [2:0] CODE_OPEN = 3'h2;
    localparam logic [2:0] CODE_SHORT = 3'h3;
    localparam logic [2:0] CODE_NORMAL = 3'h1;
    localparam logic [1:0] CMD_EDGES = 2'h3;
    // Detection capture happens on the third rise after oe_n falls.
    localparam logic [1:0] CAPTURE_EDGES = 2'h3;
    // Clock and shift-clock timing.
    localparam int CLK_MHZ = 200;
    localparam logic [3:0] SCK_HALF_CYC = 4'h4;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC_I = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0] SETTLE_CYC = SETTLE_CYC_I[9:0];
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [CNT_W-1:0] LAST_CODE = 5'h02;
    localparam logic [CNT_W-1:0] LAST_DET = 5'h02;

    typedef enum logic [1:0]
    {
        MODE_NORMAL = 2'h0,
        MODE_OPEN = 2'h1,
        MODE_SHORT = 2'h3
    } lfd_mode_t;

    typedef enum logic [2:0]
    {
        OP_WRITE = 3'h0,
        OP_MODE_OPEN = 3'h1,
        OP_MODE_SHORT = 3'h2,
        OP_MODE_NORMAL = 3'h3,
        OP_DETECT = 3'h4
    } lfd_op_t;

    typedef enum logic [2:0]
    {
        C_IDLE = 3'h0,
        C_SHIFT = 3'h1,
        C_LATCH = 3'h3,
        C_CMD = 3'h2,
        C_DET = 3'h6,
        C_READ = 3'h7
    } lfd_cstate_t;
endpackage

// ===== hdl/lfd_link_if.sv
// Serial link between the display controller and the LED sink driver.
`timescale 1ns/1ps
interface lfd_link_if;
    logic sck;
    logic serial_in;
    logic latch_strobe_n;
    logic oe_n;
    logic serial_out;

    modport dev
    (
        input sck,
        input serial_in,
        input latch_strobe_n,
        input oe_n,
        output serial_out
    );

    modport ctl
    (
        output sck,
        output serial_in,
        output latch_strobe_n,
        output oe_n,
        input serial_out
    );
endinterface

// ===== hdl/lfd_device.sv
// LED sink driver end: shift register, latch, mode decoder, fault capture.
`timescale 1ns/1ps
module lfd_device
    import lfd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    lfd_link_if.dev link,
    input wire logic [WORD_W-1:0] i_open_hit,
    input wire logic [WORD_W-1:0] i_short_hit,
    output logic [WORD_W-1:0] o_sink_on,
    output lfd_mode_t o_mode,
    output logic o_capture,
    output logic o_bad_cmd
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers. Bit order: sck, serial_in, latch_strobe_n, oe_n.

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;
    logic sck_rise;
    logic lat_release;
    logic oe_fall;
    logic sin_s;
    logic lat_n_s;
    logic oe_n_s;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            sync1_ff <= 4'h7;
            sync2_ff <= 4'h7;
            prev_ff <= 4'h7;
        end
        else
        begin
            sync1_ff <= {link.sck, link.serial_in, link.latch_strobe_n, link.oe_n};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign sin_s = sync2_ff[2];
    assign lat_n_s = sync2_ff[1];
    assign oe_n_s = sync2_ff[0];
    assign sck_rise = sync2_ff[3] & ~prev_ff[3];
    assign lat_release = sync2_ff[1] & ~prev_ff[1];
    assign oe_fall = ~sync2_ff[0] & prev_ff[0];

////////////////////////////////////////////////////////////////////////////////
// Mode command decoder.

    lfd_mode_t mode_ff;
    logic [2:0] code_ff;
    logic [1:0] cmd_edges_ff;
    logic bad_cmd_ff;
    logic plain_latch;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            code_ff <= 3'h0;
            cmd_edges_ff <= 2'h0;
        end
        else if (lat_release)
        begin
            code_ff <= 3'h0;
            cmd_edges_ff <= 2'h0;
        end
        else if (sck_rise && !lat_n_s)
        begin
            code_ff <= {code_ff[1:0], oe_n_s};
            if (cmd_edges_ff != CMD_EDGES)
            begin
                cmd_edges_ff <= cmd_edges_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            mode_ff <= MODE_NORMAL;
            bad_cmd_ff <= 1'b0;
        end
        else
        begin
            bad_cmd_ff <= 1'b0;
            if (lat_release && cmd_edges_ff != 2'h0)
            begin
                if (cmd_edges_ff != CMD_EDGES)
                begin
                    bad_cmd_ff <= 1'b1;
                end
                else if (code_ff == CODE_OPEN)
                begin
                    mode_ff <= MODE_OPEN;
                end
                else if (code_ff == CODE_SHORT)
                begin
                    mode_ff <= MODE_SHORT;
                end
                else if (code_ff == CODE_NORMAL)
                begin
                    mode_ff <= MODE_NORMAL;
                end
                else
                begin
                    bad_cmd_ff <= 1'b1;
                end
            end
        end
    end

    // A strobe with shift-clock rises under it is a command, never a latch.
    assign plain_latch = lat_release && cmd_edges_ff == 2'h0 && mode_ff == MODE_NORMAL;

////////////////////////////////////////////////////////////////////////////////
// Detection window and shift register.

    logic detecting;
    logic [1:0] det_edges_ff;
    logic capture;
    logic [WORD_W-1:0] status;
    logic [WORD_W-1:0] shift_ff;
    logic capture_ff;

    // Commands also wiggle oe_n, so a window needs the strobe released.
    assign detecting = mode_ff != MODE_NORMAL && !oe_n_s && lat_n_s;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || oe_fall)
        begin
            det_edges_ff <= 2'h0;
        end
        else if (sck_rise && detecting && det_edges_ff != CAPTURE_EDGES)
        begin
            det_edges_ff <= det_edges_ff + 2'h1;
        end
    end

    assign capture = sck_rise && detecting && det_edges_ff == CAPTURE_EDGES - 2'h1;

    logic [WORD_W-1:0] open_s1_ff;
    logic [WORD_W-1:0] open_s2_ff;
    logic [WORD_W-1:0] short_s1_ff;
    logic [WORD_W-1:0] short_s2_ff;

    // Comparator flags change on their own time, so they are synchronised as well.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            open_s1_ff <= {WORD_W{1'b0}};
            open_s2_ff <= {WORD_W{1'b0}};
            short_s1_ff <= {WORD_W{1'b0}};
            short_s2_ff <= {WORD_W{1'b0}};
        end
        else
        begin
            open_s1_ff <= i_open_hit;
            open_s2_ff <= open_s1_ff;
            short_s1_ff <= i_short_hit;
            short_s2_ff <= short_s1_ff;
        end
    end

    always_comb
    begin
        case (mode_ff)
            MODE_OPEN: status = ~open_s2_ff;
            MODE_SHORT: status = ~short_s2_ff;
            default: status = {WORD_W{1'b1}};
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            shift_ff <= {WORD_W{1'b0}};
        end
        else if (capture)
        begin
            shift_ff <= status;
        end
        else if (sck_rise && !detecting)
        begin
            shift_ff <= {shift_ff[WORD_W-2:0], sin_s};
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            capture_ff <= 1'b0;
        end
        else
        begin
            capture_ff <= capture;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Output latch and current sinks.

    logic [WORD_W-1:0] latch_ff;
    logic [WORD_W-1:0] sink_ff;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            latch_ff <= {WORD_W{1'b0}};
        end
        else if (plain_latch)
        begin
            latch_ff <= shift_ff;
        end
    end

    // Sinks follow oe_n in every mode
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            sink_ff <= {WORD_W{1'b0}};
        end
        else
        begin
            sink_ff <= latch_ff & {WORD_W{~oe_n_s}};
        end
    end

    assign link.serial_out = shift_ff[WORD_W-1];
    assign o_sink_on = sink_ff;
    assign o_mode = mode_ff;
    assign o_capture = capture_ff;
    assign o_bad_cmd = bad_cmd_ff;
endmodule

// ===== tb/lfd_properties.sv
// Link-level checks between the display controller and the sink driver.
`timescale 1ns/1ps
module lfd_properties
    import lfd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic sck,
    input wire logic serial_in,
    input wire logic latch_strobe_n,
    input wire logic oe_n,
    input wire logic serial_out
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    logic sck_ff;
    logic oe_ff;
    logic stb_ff;
    logic win_ff;
    logic armed_ff;
    logic [9:0] since_ff;
    logic [4:0] wrise_ff;
    logic [7:0] run_ff;
    logic [2:0] cmd_ff;
    wire sck_up = sck && !sck_ff;
    wire oe_dn = !oe_n && oe_ff && latch_strobe_n;
    wire stb_dn = !latch_strobe_n && stb_ff;
    wire stb_up = latch_strobe_n && !stb_ff;
    wire third_up = win_ff && sck_up && wrise_ff == 5'h02;

    ////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk)
    begin
        sck_ff <= i_rst ? 1'b0 : sck;
        oe_ff <= i_rst ? 1'b1 : oe_n;
        stb_ff <= i_rst ? 1'b1 : latch_strobe_n;
    end

    // The window opens only on an enable fall outside a command.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst || oe_n)
            win_ff <= 1'b0;
        else if (oe_dn)
            win_ff <= 1'b1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (oe_dn)
            since_ff <= 10'h001;
        else if (win_ff && since_ff != 10'h3ff)
            since_ff <= since_ff + 10'h001;
    end

    always_ff @(posedge i_mclk)
    begin
        if (oe_dn)
            wrise_ff <= 5'h00;
        else if (win_ff && sck_up && wrise_ff != 5'h1f)
            wrise_ff <= wrise_ff + 5'h01;
    end

    // Rises since the last enable change or latch; wraps at 256; a_whole_words uses only the low four bits, a_read_count the whole count.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst || oe_n != oe_ff || (latch_strobe_n && !stb_ff))
            run_ff <= 8'h00;
        else if (sck_up)
            run_ff <= run_ff + 8'h01;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || stb_dn)
            cmd_ff <= 3'h0;
        else if (sck_up && !latch_strobe_n)
            cmd_ff <= cmd_ff + 3'h1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || stb_dn || oe_dn)
            armed_ff <= 1'b0;
        else if (win_ff && oe_n)
            armed_ff <= 1'b1;
    end

    ////////////////////////////////////////////////////////////
    a_sck_half: assert property ($changed(sck) |=> $stable(sck) [*2])
        else $error("shift clock level held too briefly");
    a_third_late: assert property (third_up |-> since_ff >= SETTLE_CYC)
        else $error("capture rise too soon after enable fall");
    a_three_rises: assert property (win_ff && oe_n |-> wrise_ff >= 5'h03)
        else $error("enable raised before three shift rises");
    a_read_count: assert property (armed_ff && (stb_dn || oe_dn) |-> run_ff >= 8'h10)
        else $error("status read cut short");
    a_whole_words: assert property (stb_dn || oe_dn |-> run_ff[3:0] == 4'h0)
        else $error("word not a whole number of sixteen bits");
    a_cmd_rises: assert property (stb_up |-> cmd_ff == 3'h0 || cmd_ff == 3'h3)
        else $error("strobe held over a wrong number of rises");
    a_window_strobe: assert property (win_ff |-> latch_strobe_n)
        else $error("strobe moved inside detection window");
    a_serial_out_on_clock: assert property ($changed(serial_out) |-> sck || $past(sck))
        else $error("serial output moved without a shift clock");
endmodule

// ===== tb/lfd_bench.sv
// Self-checking bench: controller and sink driver joined over the link.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        checked = checked + 1; \
        if ((got) !== (exp)) \
        begin \
            mismatches = mismatches + 1; \
            $display("unexpected %s: expected %h seen %h", nm, exp, got); \
        end \
    end
module lfd_bench
    import lfd_pkg::*;
;
    localparam logic [WORD_W-1:0] A_WORD = 16'ha5c3;
    localparam logic [WORD_W-1:0] C_WORD = 16'h3c5a;
    localparam logic [WORD_W-1:0] PATS [3] = '{16'h8001, 16'h0000, 16'hffff};
    logic i_mclk;
    logic i_rst;
    logic op_valid;
    lfd_op_t op;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] open_hit;
    logic [WORD_W-1:0] short_hit;
    logic [WORD_W-1:0] sink_on;
    lfd_mode_t mode;
    logic capture;
    logic bad_cmd;
    logic bad_seen;
    logic op_ready;
    logic done;
    logic [WORD_W-1:0] status;
    int mismatches;
    int checked;

    lfd_link_if link();
    lfd_device u_lfd_device (.i_mclk(i_mclk), .i_rst(i_rst), .link(link),
        .i_open_hit(open_hit), .i_short_hit(short_hit), .o_sink_on(sink_on),
        .o_mode(mode), .o_capture(capture), .o_bad_cmd(bad_cmd));
    lfd_ctrl u_lfd_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .link(link),
        .i_op_valid(op_valid), .i_op(op), .i_wdata(wdata), .o_op_ready(op_ready),
        .o_done(done), .o_status(status));
    lfd_properties u_lfd_properties (.i_mclk(i_mclk), .i_rst(i_rst), .sck(link.sck),
        .serial_in(link.serial_in), .latch_strobe_n(link.latch_strobe_n),
        .oe_n(link.oe_n), .serial_out(link.serial_out));

    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic limit(input int n, input int max);
        if (n >= max)
        begin
            mismatches++;
            $display("unexpected wait: expected below %0d seen %0d", max, n);
            results();
        end
    endtask

    // Sinks are sampled well inside the window, before the capture rise.
    task automatic run_op(input lfd_op_t o, input logic [WORD_W-1:0] d,
        input logic [WORD_W-1:0] exp_sink, input logic [WORD_W-1:0] exp_stat,
        input int exp_cap);
        int n;
        int caps;
        caps = 0;
        for (n = 0; n < 50 && op_ready !== 1'b1; n++)
            @(negedge i_mclk);
        limit(n, 50);
        op_valid = 1'b1;
        op = o;
        wdata = d;
        @(negedge i_mclk);
        op_valid = 1'b0;
        for (n = 0; n < 2000 && done !== 1'b1; n++)
        begin
            if (n == 100 && o == OP_DETECT)
                `CHECK("sink", exp_sink, sink_on)
            caps += (capture === 1'b1);
            @(negedge i_mclk);
        end
        limit(n, 2000);
        if (o == OP_DETECT)
        begin
            `CHECK("captures", exp_cap, caps)
            if (exp_cap == 1)
                `CHECK("status", exp_stat, status)
        end
    endtask

    task automatic set_mode(input lfd_op_t o, input lfd_mode_t m);
        int n;
        run_op(o, 16'h0000, 16'h0000, 16'h0000, 0);
        for (n = 0; n < 20 && mode !== m; n++)
            @(negedge i_mclk);
        `CHECK("mode", m, mode)
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk)
        if (i_rst)
            bad_seen <= 1'b0;
        else if (bad_cmd === 1'b1)
            bad_seen <= 1'b1;

    initial
    begin
        int k;
        mismatches = 0;
        checked = 0;
        i_rst = 1'b1;
        op_valid = 1'b0;
        op = OP_WRITE;
        wdata = 16'h0000;
        open_hit = 16'h0000;
        short_hit = 16'h0000;
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        `CHECK("reset mode", MODE_NORMAL, mode)
        `CHECK("reset sink", 16'h0000, sink_on)
        `CHECK("reset link", 3'h3, {link.sck, link.oe_n, link.latch_strobe_n})
        run_op(OP_WRITE, A_WORD, 16'h0000, 16'h0000, 0);
        run_op(OP_DETECT, 16'h0000, A_WORD, 16'h0000, 0);
        set_mode(OP_MODE_OPEN, MODE_OPEN);
        run_op(OP_WRITE, 16'h0ff0, 16'h0000, 16'h0000, 0);
        for (k = 0; k < 3; k++)
        begin
            open_hit = PATS[k];
            short_hit = ~PATS[k];
            run_op(OP_DETECT, 16'h0000, A_WORD, ~PATS[k], 1);
        end
        set_mode(OP_MODE_SHORT, MODE_SHORT);
        run_op(OP_WRITE, 16'h0ff0, 16'h0000, 16'h0000, 0);
        for (k = 0; k < 3; k++)
        begin
            short_hit = PATS[k];
            open_hit = ~PATS[k];
            run_op(OP_DETECT, 16'h0000, A_WORD, ~PATS[k], 1);
        end
        set_mode(OP_MODE_NORMAL, MODE_NORMAL);
        run_op(OP_WRITE, C_WORD, 16'h0000, 16'h0000, 0);
        run_op(OP_DETECT, 16'h0000, C_WORD, 16'h0000, 0);
        `CHECK("bad command", 1'b0, bad_seen)
        results();
    end
endmodule
